/* File: hw/fsq_cmd_top.sv */
// Security-area, read-parameter and quad-mode command handling of the serial flash.
//
// What this block does
// - Three separate 256-byte security areas, each erased and programmed on its own.
// - Area erase is taken only while the write permit latch is set.
// - Erase opcode 44h; address bits 15:12 pick area 1 to 3; bits 31:16 and 11:8 zero.
// - Erase runs only if chip select rises right after the last byte.
// - A valid erase runs self-timed with busy held high until done.
// - Erase completion clears the write permit latch and busy.
// - Erase of an area whose lock bit is set is ignored.
// - Program of a locked area is ignored; contents stay unchanged.
// - Program opcode 42h, area address, one to 256 bytes, write permit needed.
// - Read opcode 48h, address and eight dummy clocks, sampled on rising edges.
// - Read data leaves on falling clock edges, most significant bit first.
// - Read pointer steps each byte and wraps from FFh to 00h.
// - Area read while busy is ignored and leaves the cycle alone.
// - Read-parameter command C0h is taken only in quad command mode.
// - Dummy code 00 to 11 selects 2, 4, 6 or 8 clocks.
// - Wrap code 00 to 11 selects 8, 16, 32 or 64 bytes.
// - After power-up or reset, wrap is 8 bytes and dummy count 2.
// - Configured dummy count applies to 0Bh, EBh and 0Ch in quad mode only.
// - Wrapped read 0Ch wraps its address inside the aligned wrap window.
// - Device starts in serial mode; only 38h enters quad mode.
// - 38h is ignored while the four-wire permit bit is low.
// - Entering quad mode keeps write permit but resets wrap length.
// - Leaving quad mode by FFh keeps write permit and wrap length.
// - Reset-enable 66h then reset 99h restores all volatile defaults.
`timescale 1ns/1ps
module fsq_cmd_top
  import fsq_pkg::*;
#(
  parameter int unsigned AREA_ERASE_CYCLES = AREA_ERASE_TIME_US * CLK_MHZ
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Serial pins, inputs sampled and outputs registered on the system clock
  input  wire logic        i_cs_n,
  input  wire logic        i_sclk,
  input  wire logic [3:0]  i_io_in,
  output logic      [3:0]  o_io_out,
  output logic      [3:0]  o_io_oe,
  // Status inputs
  input  wire logic        i_addr_4byte,
  input  wire logic        i_four_wire_permit_bit,
  input  wire logic [2:0]  i_area_otp_lock_bits,
  // Status and configuration outputs
  output logic             o_busy,
  output logic             o_write_permit_latch,
  output logic             o_quad_command_mode,
  output logic      [1:0]  o_read_dummy_code,
  output logic      [1:0]  o_wrap_length_field,
  // Main-array read address stream
  output logic             o_array_read,
  output logic      [31:0] o_array_addr
);
  fsq_state_type state_r, state_nxt, cmd_state, addr_state;
  logic             sclk_q_r, cs_q_r;
  logic [7:0]       sh_r, op_r, ptr_r, osh_r, buf0_r, buf1_r, rdata;
  logic [3:0]       bit_r, obit_r, dcnt_r, io_out_r, io_oe_r;
  logic [2:0]       abytes_r;
  logic [31:0]      addr_r, aaddr_r;
  logic [1:0]       area_r, dcode_r, wcode_r, cnt_r;
  logic             wel_r, qpi_r, busy_r, erasing_r, rsten_r, prog_any_r, pend_r, aread_r;
  logic [TMR_W-1:0] tmr_r;
  logic [8:0]       sweep_r;

  // Serial clock edges seen by the system clock; the serial clock must stay well below it.
  wire        rise      = i_sclk & ~sclk_q_r & ~i_cs_n;
  wire        fall      = ~i_sclk & sclk_q_r & ~i_cs_n;
  wire        cs_rise   = i_cs_n & ~cs_q_r;
  wire [3:0]  step      = qpi_r ? BEAT_QUAD : BEAT_SERIAL;
  wire [3:0]  bit_sum   = bit_r + step;
  wire [3:0]  obit_sum  = obit_r + step;
  wire [7:0]  in_byte   = qpi_r ? {sh_r[3:0], i_io_in} : {sh_r[6:0], i_io_in[0]};
  wire        byte_done = rise && (bit_sum == BYTE_BITS);
  wire [31:0] addr_full = {addr_r[23:0], in_byte};
  wire [2:0]  addr_len  = i_addr_4byte ? ADDR_BYTES_LONG : ADDR_BYTES_SHORT;
  wire        addr_last = byte_done && (state_r == ST_ADDR) && (abytes_r + 3'h1 == addr_len);

  // Area decode of the incoming address.
  wire [3:0]  area_sel    = addr_full[AREA_SEL_LSB +: 4];
  wire        area_ok     = (addr_full[31:AREA_HI_LSB] == '0)
                            && (addr_full[AREA_PAD_LSB +: 4] == '0)
                            && (area_sel >= AREA_FIRST) && (area_sel <= AREA_LAST);
  wire [1:0]  area_new    = area_sel[1:0];
  wire        area_locked = i_area_otp_lock_bits[area_new - 2'h1];

  // Opcode classes.
  wire        is_array_rd = (in_byte == OP_FAST_READ) || (in_byte == OP_QUAD_READ)
                            || (in_byte == OP_WRAP_READ);
  wire        is_single   = (in_byte == OP_ENTER_QUAD) || (in_byte == OP_EXIT_QUAD)
                            || (in_byte == OP_RESET_EN) || (in_byte == OP_RESET)
                            || (in_byte == OP_WRITE_EN) || (in_byte == OP_WRITE_DIS);
  wire        wr_refused  = busy_r | ~wel_r;

  assign cmd_state =
    ((in_byte == OP_AREA_ERASE) || (in_byte == OP_AREA_PROG)) ?
      (wr_refused ? ST_IGNORE : ST_ADDR) :
    (in_byte == OP_AREA_READ) ? (busy_r ? ST_IGNORE : ST_ADDR) :
    (in_byte == OP_SET_PARAM) ? ((qpi_r && !busy_r) ? ST_PARAM : ST_IGNORE) :
    is_array_rd ? ((qpi_r && !busy_r) ? ST_ADDR : ST_IGNORE) :
    is_single ? ST_TAIL : ST_IGNORE;

  assign addr_state =
    (op_r == OP_AREA_ERASE) ? ((area_ok && !area_locked) ? ST_TAIL : ST_IGNORE) :
    (op_r == OP_AREA_PROG) ? ((area_ok && !area_locked) ? ST_PDATA : ST_IGNORE) :
    (op_r == OP_AREA_READ) ? (area_ok ? ST_DUMMY : ST_IGNORE) : ST_DUMMY;

  // Dummy count and wrap window from the read parameters.
  wire [3:0]  cfg_dummy = {1'b0, dcode_r, 1'b0} + DUMMY_BASE;
  wire [7:0]  wrap_mask = (WRAP_BASE << wcode_r) - 8'h01;
  wire [31:0] seq_next  = aaddr_r + 32'h1;
  wire [31:0] wrap_next = (aaddr_r & ~{24'h0, wrap_mask}) | (seq_next & {24'h0, wrap_mask});

  // Command completion events; all but tmr_end and param_load occur at chip select release.
  wire tail_done   = cs_rise && (state_r == ST_TAIL);
  wire do_reset    = tail_done && (op_r == OP_RESET) && rsten_r;
  wire start_erase = tail_done && (op_r == OP_AREA_ERASE);
  wire start_prog  = cs_rise && (state_r == ST_PDATA) && prog_any_r;
  wire quad_enter  = tail_done && (op_r == OP_ENTER_QUAD) && i_four_wire_permit_bit;
  wire quad_leave  = tail_done && (op_r == OP_EXIT_QUAD);
  wire tmr_end     = busy_r && (tmr_r == TMR_W'(1));
  wire param_load  = byte_done && (state_r == ST_PARAM);

  // Two-entry buffer between the area store and the output shifter.
  wire        fetch_state = (state_r == ST_DUMMY) || (state_r == ST_SOUT);
  wire        room        = (cnt_r + {1'b0, pend_r}) < BUF_DEPTH;
  wire        fetch_go    = ~i_cs_n && fetch_state && (op_r == OP_AREA_READ) && room;
  wire        fill_ready  = (cnt_r != BUF_DEPTH);
  wire        push        = pend_r && fill_ready;
  wire        pop         = fall && (state_r == ST_SOUT) && (obit_r == 4'h0) && (cnt_r != 2'h0);
  wire [7:0]  cur_byte    = (obit_r == 4'h0) ? buf0_r : osh_r;

  // Store access; the erase sweep and programming never overlap because a program command is refused while busy.
  wire        prog_wr  = byte_done && (state_r == ST_PDATA);
  wire        sweep_wr = erasing_r && ~sweep_r[8];
  wire [1:0]  area_ix  = area_r - 2'h1;
  wire [9:0]  mem_addr = {area_ix, sweep_wr ? sweep_r[7:0] : ptr_r};

  fsq_area_mem u_mem (
    .i_sys_clk (i_sys_clk),
    .i_wr_en   (sweep_wr | prog_wr),
    .i_erase   (sweep_wr),
    .i_waddr   (mem_addr),
    .i_wdata   (in_byte),
    .i_rd_en   (fetch_go),
    .i_raddr   (mem_addr),
    .o_rdata   (rdata)
  );

  always_comb begin
    state_nxt = state_r;
    if (i_cs_n) begin
      state_nxt = ST_CMD;
    end else begin
      unique case (state_r)
        ST_CMD:    if (byte_done) state_nxt = cmd_state;
        ST_ADDR:   if (addr_last) state_nxt = addr_state;
        ST_DUMMY:  if (rise && dcnt_r == 4'h1) begin
          state_nxt = (op_r == OP_AREA_READ) ? ST_SOUT : ST_ARRAY;
        end
        ST_PARAM:  if (byte_done) state_nxt = ST_TAIL;
        ST_TAIL:   if (rise) state_nxt = ST_IGNORE;
        ST_PDATA, ST_SOUT, ST_ARRAY, ST_IGNORE: state_nxt = state_r;
        default:   state_nxt = ST_IGNORE;
      endcase
    end
  end

  // Frame tracking and input shifting.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r  <= ST_CMD;
      sclk_q_r <= 1'b0;
      cs_q_r   <= 1'b1;
      sh_r     <= '0;
      bit_r    <= '0;
    end else begin
      state_r  <= state_nxt;
      sclk_q_r <= i_sclk;
      cs_q_r   <= i_cs_n;
      if (rise) sh_r <= in_byte;
      if (i_cs_n) bit_r <= '0;
      else if (rise) bit_r <= byte_done ? 4'h0 : bit_sum;
    end
  end

  // Opcode, address and pointers.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_r     <= '0;
      addr_r   <= '0;
      abytes_r <= '0;
      area_r   <= AREA_FIRST[1:0];
      ptr_r    <= '0;
      dcnt_r   <= '0;
    end else begin
      if (state_r == ST_CMD && byte_done) op_r <= in_byte;
      if (i_cs_n) begin
        addr_r   <= '0;
        abytes_r <= '0;
      end else if (byte_done && state_r == ST_ADDR) begin
        addr_r   <= addr_full;
        abytes_r <= abytes_r + 3'h1;
      end
      if (addr_last) begin
        area_r <= area_new;
        ptr_r  <= addr_full[7:0];
        dcnt_r <= (op_r == OP_AREA_READ) ? AREA_READ_DUMMY : cfg_dummy;
      end else begin
        if (prog_wr || fetch_go) ptr_r <= ptr_r + 8'h01;
        if (rise && state_r == ST_DUMMY) dcnt_r <= dcnt_r - 4'h1;
      end
    end
  end

  // Main-array address stream for the configurable fast reads.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aaddr_r <= '0;
      aread_r <= 1'b0;
    end else begin
      aread_r <= (state_r == ST_DUMMY && state_nxt == ST_ARRAY)
                 || (state_r == ST_ARRAY && byte_done);
      if (addr_last) aaddr_r <= addr_full;
      else if (state_r == ST_ARRAY && byte_done) begin
        aaddr_r <= (op_r == OP_WRAP_READ) ? wrap_next : seq_next;
      end
    end
  end

  // Buffer storage.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= '0;
      pend_r <= 1'b0;
      buf0_r <= '0;
      buf1_r <= '0;
    end else begin
      pend_r <= fetch_go;
      if (i_cs_n) cnt_r <= '0;
      else cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      if (pop) buf0_r <= (push && cnt_r == 2'h1) ? rdata : buf1_r;
      else if (push && cnt_r == 2'h0) buf0_r <= rdata;
      if (push && (cnt_r == 2'h2 || (cnt_r == 2'h1 && !pop))) buf1_r <= rdata;
    end
  end

  // Output shifter, driven on falling serial clock edges.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osh_r    <= '0;
      obit_r   <= '0;
      io_out_r <= '0;
      io_oe_r  <= '0;
    end else if (i_cs_n) begin
      obit_r  <= '0;
      io_oe_r <= '0;
    end else if (fall && state_r == ST_SOUT) begin
      osh_r    <= qpi_r ? {cur_byte[3:0], 4'h0} : {cur_byte[6:0], 1'b0};
      io_out_r <= qpi_r ? cur_byte[7:4] : {2'b00, cur_byte[7], 1'b0};
      io_oe_r  <= qpi_r ? OE_QUAD : OE_SERIAL;
      obit_r   <= (obit_sum == BYTE_BITS) ? 4'h0 : obit_sum;
    end
  end

  // Write permit latch, busy timer and erase sweep.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wel_r      <= 1'b0;
      busy_r     <= 1'b0;
      erasing_r  <= 1'b0;
      tmr_r      <= '0;
      sweep_r    <= '0;
      prog_any_r <= 1'b0;
    end else begin
      if (do_reset || tmr_end) wel_r <= 1'b0;
      else if (tail_done && op_r == OP_WRITE_EN) wel_r <= 1'b1;
      else if (tail_done && op_r == OP_WRITE_DIS) wel_r <= 1'b0;
      if (do_reset || tmr_end) begin
        busy_r    <= 1'b0;
        erasing_r <= 1'b0;
      end else if (start_erase) begin
        busy_r    <= 1'b1;
        erasing_r <= 1'b1;
        tmr_r     <= TMR_W'(AREA_ERASE_CYCLES);
        sweep_r   <= '0;
      end else if (start_prog) begin
        busy_r <= 1'b1;
        tmr_r  <= TMR_W'(PROG_CYCLES);
      end else if (busy_r) begin
        tmr_r <= tmr_r - TMR_W'(1);
      end
      if (sweep_wr && !start_erase) sweep_r <= sweep_r + 9'h001;
      if (i_cs_n) prog_any_r <= 1'b0;
      else if (prog_wr) prog_any_r <= 1'b1;
    end
  end

  // Mode and read parameters.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      qpi_r   <= 1'b0;
      dcode_r <= DUMMY_CODE_RST;
      wcode_r <= WRAP_CODE_RST;
      rsten_r <= 1'b0;
    end else begin
      if (do_reset || quad_leave) qpi_r <= 1'b0;
      else if (quad_enter) qpi_r <= 1'b1;
      if (do_reset) dcode_r <= DUMMY_CODE_RST;
      else if (param_load) dcode_r <= in_byte[DUMMY_FIELD_LSB +: 2];
      if (do_reset || quad_enter) wcode_r <= WRAP_CODE_RST;
      else if (param_load) wcode_r <= in_byte[WRAP_FIELD_LSB +: 2];
      if (cs_rise && state_r != ST_CMD) rsten_r <= tail_done && (op_r == OP_RESET_EN);
    end
  end

  assign o_io_out             = io_out_r;
  assign o_io_oe              = io_oe_r;
  assign o_busy               = busy_r;
  assign o_write_permit_latch = wel_r;
  assign o_quad_command_mode  = qpi_r;
  assign o_read_dummy_code    = dcode_r;
  assign o_wrap_length_field  = wcode_r;
  assign o_array_read         = aread_r;
  assign o_array_addr         = aaddr_r;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_erase_start;
    $rose(erasing_r);
  endsequence

  a_erase_needs_wel: assert property (s_erase_start |-> $past(wel_r))
    else $error("erase started without write permit");
  a_erase_area_open: assert property (s_erase_start |->
      !$past(i_area_otp_lock_bits[area_ix], 2))
    else $error("erase started on a locked area");
  a_erase_busy: assert property (s_erase_start |-> busy_r ##1 busy_r[*8])
    else $error("busy not held during erase");
  a_done_clears_wel: assert property ($fell(busy_r) && !$past(do_reset) |-> !wel_r)
    else $error("write permit still set after cycle end");
  a_read_not_busy: assert property (state_r == ST_SOUT |-> !busy_r)
    else $error("area read running while busy");
  a_param_quad_only: assert property ($changed(dcode_r) |->
      $past(qpi_r) || $past(do_reset))
    else $error("read parameters changed outside quad mode");
  a_quad_permit: assert property ($rose(qpi_r) |-> $past(i_four_wire_permit_bit))
    else $error("quad mode entered without permit bit");
  a_quad_wrap_rst: assert property ($rose(qpi_r) |-> wcode_r == WRAP_CODE_RST)
    else $error("wrap length kept on quad entry");
  a_ptr_wrap: assert property (fetch_go && ptr_r == '1 |=> ptr_r == '0)
    else $error("read pointer left its area");
  a_out_msb: assert property (pop && !qpi_r |=> o_io_out[1] == $past(buf0_r[7]))
    else $error("serial read byte not sent msb first");
  a_wrap_window: assert property (aread_r && op_r == OP_WRAP_READ && state_r == ST_ARRAY
      |-> (aaddr_r & ~{24'h0, wrap_mask}) == ($past(aaddr_r) & ~{24'h0, wrap_mask}))
    else $error("wrapped read left its window");
endmodule

/* File: hw/fsq_pkg.sv */
// Shared opcodes, field positions, defaults and timing for the security-area command block.
package fsq_pkg;
  localparam int unsigned CLK_MHZ = 20;

  localparam logic [7:0] OP_AREA_ERASE = 8'h44;
  localparam logic [7:0] OP_AREA_PROG  = 8'h42;
  localparam logic [7:0] OP_AREA_READ  = 8'h48;
  localparam logic [7:0] OP_SET_PARAM  = 8'hc0;
  localparam logic [7:0] OP_FAST_READ  = 8'h0b;
  localparam logic [7:0] OP_QUAD_READ  = 8'heb;
  localparam logic [7:0] OP_WRAP_READ  = 8'h0c;
  localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
  localparam logic [7:0] OP_EXIT_QUAD  = 8'hff;
  localparam logic [7:0] OP_RESET_EN   = 8'h66;
  localparam logic [7:0] OP_RESET      = 8'h99;
  localparam logic [7:0] OP_WRITE_EN   = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS  = 8'h04;

  localparam int         AREA_HI_LSB   = 16;
  localparam int         AREA_SEL_LSB  = 12;
  localparam int         AREA_PAD_LSB  = 8;
  localparam logic [3:0] AREA_FIRST    = 4'h1;
  localparam logic [3:0] AREA_LAST     = 4'h3;
  localparam int         AREA_WORDS    = 768;
  localparam logic [7:0] ERASED_BYTE   = 8'hff;

  localparam logic [2:0] ADDR_BYTES_SHORT = 3'h3;
  localparam logic [2:0] ADDR_BYTES_LONG  = 3'h4;
  localparam logic [3:0] BEAT_SERIAL      = 4'h1;
  localparam logic [3:0] BEAT_QUAD        = 4'h4;
  localparam logic [3:0] BYTE_BITS        = 4'h8;
  localparam logic [3:0] OE_SERIAL        = 4'h2;
  localparam logic [3:0] OE_QUAD          = 4'hf;

  localparam int         DUMMY_FIELD_LSB = 4;
  localparam int         WRAP_FIELD_LSB  = 0;
  localparam logic [1:0] DUMMY_CODE_RST  = 2'h0;
  localparam logic [1:0] WRAP_CODE_RST   = 2'h0;
  localparam logic [3:0] DUMMY_BASE      = 4'h2;
  localparam logic [7:0] WRAP_BASE       = 8'h08;
  localparam logic [3:0] AREA_READ_DUMMY = 4'h8;

  localparam logic [1:0] BUF_DEPTH = 2'h2;

  localparam int          TMR_W              = 24;
  localparam int unsigned PROG_TIME_NS       = 500;
  localparam int unsigned PROG_CYCLES        = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned AREA_ERASE_TIME_US = 1000;

  typedef enum logic [3:0] {
    ST_CMD    = 4'h0,
    ST_ADDR   = 4'h1,
    ST_DUMMY  = 4'h2,
    ST_PDATA  = 4'h3,
    ST_PARAM  = 4'h4,
    ST_SOUT   = 4'h5,
    ST_ARRAY  = 4'h6,
    ST_TAIL   = 4'h7,
    ST_IGNORE = 4'h8
  } fsq_state_type;
endpackage

/* File: hw/fsq_area_mem.sv */
// Storage of the three security areas with a registered read port.
`timescale 1ns/1ps
module fsq_area_mem
  import fsq_pkg::*;
(
  // Clock
  input  wire logic       i_sys_clk,
  // Write port
  input  wire logic       i_wr_en,
  input  wire logic       i_erase,
  input  wire logic [9:0] i_waddr,
  input  wire logic [7:0] i_wdata,
  // Read port
  input  wire logic       i_rd_en,
  input  wire logic [9:0] i_raddr,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem_r [AREA_WORDS];

  // Programming can only clear bits, so a byte written twice is the AND of both values.
  always_ff @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem_r[i_waddr] <= i_erase ? ERASED_BYTE : (mem_r[i_waddr] & i_wdata);
    end
    if (i_rd_en) begin
      o_rdata <= mem_r[i_raddr];
    end
  end
endmodule

/* File: tb/fsq_host_model.sv */
// Behavioural serial host that frames commands and clocks bits for the command block.
`timescale 1ns/1ps
module fsq_host_model (
  // Clock and mode
  input  wire logic       i_sys_clk,
  input  wire logic       i_quad,
  // Serial pins
  input  wire logic [3:0] i_io_out,
  output logic            o_cs_n,
  output logic            o_sclk,
  output logic      [3:0] o_io
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_io   = 4'h0;
  end
  // Each clock phase spans four system clocks so the device's fetch keeps up.
  task automatic tick(input logic [3:0] d, output logic [3:0] q);
    @(posedge i_sys_clk) #2 o_sclk = 1'b0;
    o_io = d;
    repeat (4) @(posedge i_sys_clk);
    #2 q = i_io_out; // Read data is taken after the fall has settled
    o_sclk = 1'b1; // Opcode, address and data are taken on the rise
    repeat (3) @(posedge i_sys_clk);
  endtask
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    logic [3:0] q;
    if (i_quad) begin
      tick(b[7:4], q);
      r[7:4] = q;
      tick(b[3:0], q);
      r[3:0] = q;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        tick({3'h0, b[i]}, q);
        r[i] = q[1];
      end
    end
  endtask
  task automatic open_frame();
    @(posedge i_sys_clk) #2 o_cs_n = 1'b0;
  endtask
  // Released data lines show the inverse, so a stale level is never mistaken for data.
  task automatic close_frame();
    @(posedge i_sys_clk) #2 o_sclk = 1'b0;
    @(posedge i_sys_clk) #2 o_cs_n = 1'b1; // Select rises right after the last bit
    o_io = ~o_io;
    repeat (3) @(posedge i_sys_clk);
  endtask
  // Select stays low over every byte of the command
  task automatic frame(input logic [7:0] b[$]);
    logic [7:0] r;
    open_frame();
    foreach (b[i]) xfer(b[i], r);
    close_frame();
  endtask
endmodule

/* File: tb/flash_secreg_qpi_cmds_tb_top.sv */
// Self-checking bench for the security-area and quad-mode command block.
`timescale 1ns/1ps
module flash_secreg_qpi_cmds_tb_top;
  import fsq_pkg::*;
  localparam int unsigned ERASE_CYC = 300;
  logic        i_sys_clk, i_rst_n, i_cs_n, i_sclk, i_addr_4byte, i_four_wire_permit_bit;
  logic [3:0]  i_io_in, o_io_out, o_io_oe, q4;
  logic [2:0]  i_area_otp_lock_bits;
  logic        o_busy, o_write_permit_latch, o_quad_command_mode, o_array_read;
  logic [1:0]  o_read_dummy_code, o_wrap_length_field;
  logic [31:0] o_array_addr, obs, got, exp_q[$], seen_addr[$];
  logic [7:0]  rd, dat[2], seq[$];
  string       name_q[$];
  int          n_mismatch, checks_done, n_busy, src_q[$];
  event        chk;
  wire  [31:0] stat = {25'h0, o_busy, o_write_permit_latch, o_quad_command_mode,
                       o_read_dummy_code, o_wrap_length_field};

  fsq_cmd_top #(.AREA_ERASE_CYCLES(ERASE_CYC)) dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_io_in(i_io_in), .o_io_out(o_io_out),
    .o_io_oe(o_io_oe), .i_addr_4byte(i_addr_4byte),
    .i_four_wire_permit_bit(i_four_wire_permit_bit),
    .i_area_otp_lock_bits(i_area_otp_lock_bits), .o_busy(o_busy),
    .o_write_permit_latch(o_write_permit_latch), .o_quad_command_mode(o_quad_command_mode),
    .o_read_dummy_code(o_read_dummy_code), .o_wrap_length_field(o_wrap_length_field),
    .o_array_read(o_array_read), .o_array_addr(o_array_addr));
  fsq_host_model host (.i_sys_clk(i_sys_clk), .i_quad(o_quad_command_mode),
    .i_io_out(o_io_out), .o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_io(i_io_in));

  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    if (o_array_read === 1'b1) seen_addr.push_back(o_array_addr);
  end
  // The watcher drains every note queued so far against the outputs as they stand.
  always @(chk) begin
    while (exp_q.size() > 0) begin
      checks_done++;
      got = (src_q.pop_front() != 0) ? obs : stat;
      if (got !== exp_q[0]) begin
        n_mismatch++;
        $display("mismatch %s expected %h seen %h", name_q[0], exp_q[0], got);
      end
      void'(exp_q.pop_front());
      void'(name_q.pop_front());
    end
  end
  function automatic logic [31:0] st(logic b, logic w, logic q, logic [1:0] d, logic [1:0] c);
    return {25'h0, b, w, q, d, c};
  endfunction
  task automatic note(input string nm, input int use_obs, input logic [31:0] e);
    name_q.push_back(nm);
    src_q.push_back(use_obs);
    exp_q.push_back(e);
    // Sampling a moment after the edge keeps the watcher clear of the registers' own update.
    #1 ->chk;
    @(posedge i_sys_clk) #2;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wait_idle(input int bound);
    n_busy = 0;
    while (o_busy !== 1'b0 && n_busy < bound) begin
      @(posedge i_sys_clk) #2 n_busy++;
    end
    if (n_busy >= bound) begin
      n_mismatch++;
      $display("mismatch busy expected 0 seen 1");
      report_and_stop();
    end
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_addr_4byte = 1'b0;
    i_four_wire_permit_bit = 1'b0;
    i_area_otp_lock_bits = 3'h0;
    void'($urandom(94));
    dat[0] = 8'($urandom());
    dat[1] = 8'($urandom());
    repeat (2) @(posedge i_sys_clk);
    #2 i_rst_n = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    note("reset status", 0, st(0, 0, 0, 2'h0, 2'h0));
    host.frame('{OP_SET_PARAM, 8'h33});
    note("serial param", 0, st(0, 0, 0, 2'h0, 2'h0));
    host.frame('{OP_WRITE_EN});
    host.frame('{OP_ENTER_QUAD});
    note("quad refused", 0, st(0, 1, 0, 2'h0, 2'h0));
    i_four_wire_permit_bit = 1'b1;
    host.frame('{OP_ENTER_QUAD});
    note("quad entry", 0, st(0, 1, 1, 2'h0, 2'h0));
    $display("test mode entry done");
    for (int k = 0; k < 4; k++) begin
      host.frame('{OP_SET_PARAM, {2'h0, 2'(k), 2'h0, 2'(3 - k)}});
      note("param codes", 0, st(0, 1, 1, 2'(k), 2'(3 - k)));
    end
    host.frame('{OP_SET_PARAM, 8'h10});
    seen_addr.delete();
    seq = '{OP_WRAP_READ, 8'h00, 8'h01, 8'h07};
    host.open_frame();
    foreach (seq[i]) host.xfer(seq[i], rd);
    repeat (4) host.tick(4'h0, q4);
    repeat (2) host.xfer(8'h00, rd);
    host.close_frame();
    obs = (seen_addr.size() > 1) ? seen_addr[0] : 32'h0;
    note("wrap start", 1, 32'h107);
    obs = (seen_addr.size() > 1) ? seen_addr[1] : 32'h0;
    note("wrap next", 1, 32'h100);
    host.frame('{OP_SET_PARAM, 8'h02});
    host.frame('{OP_EXIT_QUAD});
    note("quad exit", 0, st(0, 1, 0, 2'h0, 2'h2));
    host.frame('{OP_ENTER_QUAD});
    note("wrap on entry", 0, st(0, 1, 1, 2'h0, 2'h0));
    host.frame('{OP_SET_PARAM, 8'h33});
    host.frame('{OP_RESET_EN});
    host.frame('{OP_RESET});
    note("soft reset", 0, st(0, 0, 0, 2'h0, 2'h0));
    $display("test read parameters done");
    host.frame('{OP_AREA_ERASE, 8'h00, 8'h10, 8'h00});
    note("erase no permit", 0, st(0, 0, 0, 2'h0, 2'h0));
    i_area_otp_lock_bits = 3'h1;
    host.frame('{OP_WRITE_EN});
    host.frame('{OP_AREA_ERASE, 8'h00, 8'h10, 8'h00});
    note("erase locked", 0, st(0, 1, 0, 2'h0, 2'h0));
    i_area_otp_lock_bits = 3'h0;
    seq = '{OP_AREA_ERASE, 8'h00, 8'h10, 8'h00};
    host.open_frame();
    foreach (seq[i]) host.xfer(seq[i], rd);
    host.tick(4'h1, q4);
    host.close_frame();
    note("erase extra bit", 0, st(0, 1, 0, 2'h0, 2'h0));
    host.frame(seq);
    note("erase busy", 0, st(1, 1, 0, 2'h0, 2'h0));
    wait_idle(400);
    obs = {31'h0, n_busy > ERASE_CYC - 8 && n_busy <= ERASE_CYC};
    note("erase length", 1, 32'h1);
    note("erase done", 0, st(0, 0, 0, 2'h0, 2'h0));
    host.frame('{OP_WRITE_EN});
    host.frame('{OP_AREA_PROG, 8'h00, 8'h10, 8'hff, dat[0], dat[1]});
    wait_idle(40);
    note("program done", 0, st(0, 0, 0, 2'h0, 2'h0));
    i_area_otp_lock_bits = 3'h1;
    host.frame('{OP_WRITE_EN});
    host.frame('{OP_AREA_PROG, 8'h00, 8'h10, 8'h00, 8'h00});
    note("program locked", 0, st(0, 1, 0, 2'h0, 2'h0));
    // The second pass reads the same bytes in quad command mode with a four-byte address.
    for (int m = 0; m < 2; m++) begin
      i_addr_4byte = 1'(m);
      if (m != 0) host.frame('{OP_ENTER_QUAD});
      seq = '{OP_AREA_READ, 8'h00, 8'h10, 8'hff};
      if (m != 0) seq.insert(1, 8'h00);
      host.open_frame();
      foreach (seq[i]) host.xfer(seq[i], rd);
      repeat (8) host.tick(4'h0, q4);
      for (int i = 0; i < 2; i++) begin
        host.xfer(8'h00, rd);
        obs = {24'h0, rd};
        note("area read", 1, {24'h0, dat[i]});
        obs = {28'h0, o_io_oe};
        note("read drive", 1, (m != 0) ? 32'hf : 32'h2);
      end
      host.close_frame();
      obs = {28'h0, o_io_oe};
      note("drive released", 1, 32'h0);
    end
    $display("test security areas done");
    report_and_stop();
  end
endmodule
